// *** alu_defs.vh ***
// Purpose: Constants for the arithmetic and logic datapath slice.
// Assumes: Included by bare name from each design file.
// Notes:   Definitions only.
`ifndef ALU_DEFS_VH
`define ALU_DEFS_VH

// ********************************
// Operation codes
// ********************************
`define ALU_OP_W          4
`define ALU_OP_SIGNED_DIVIDE   4'h0
`define ALU_OP_COMPARE    4'h1
`define ALU_OP_NEGATE     4'h2
`define ALU_OP_ZERO_EXTEND 4'h3
`define ALU_OP_SIGN_EXTEND 4'h4
`define ALU_OP_AND        4'h5
`define ALU_OP_OR         4'h6
`define ALU_OP_XOR        4'h7
`define ALU_OP_NOT        4'h8

// ********************************
// Operand sizes
// ********************************
`define ALU_SZ_W          2
`define ALU_SZ_BYTE       2'h0
`define ALU_SZ_WORD       2'h1
`define ALU_SZ_LONG       2'h2

// ********************************
// Condition code field positions
// ********************************
`define ALU_CC_W          4
`define ALU_CC_C          0
`define ALU_CC_V          1
`define ALU_CC_Z          2
`define ALU_CC_N          3

// ********************************
// Divider timing
// ********************************
`define ALU_DIV_STEPS     6'h10
`define ALU_DIV_STEPS_WORD 6'h20
`define ALU_DIV_CNT_W     6

`endif

// *** alu_div.v ***
// Purpose: Sequential signed divider, byte or word size.
// Assumes: Operands held stable by the caller only at start.
// Notes:   Restoring division on magnitudes, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"

module alu_div (
	input  wire        i_clk,
	input  wire        i_resetn,
	input  wire        i_start,
	input  wire        i_word,
	input  wire [31:0] i_dividend,
	input  wire [15:0] i_divisor,
	output reg         o_done_ff,
	output reg         o_zero_div_ff,
	output reg  [15:0] o_quot_ff,
	output reg  [15:0] o_rem_ff
);

	reg         busy_ff;
	reg  [5:0]  cnt_ff;
	reg         fin_ff;
	reg  [31:0] num_ff;
	reg  [16:0] rem_ff;
	reg  [15:0] den_ff;
	reg         qneg_ff;
	reg         rneg_ff;
	reg         word_ff;

	wire        dvd_neg = i_word ? i_dividend[31] : i_dividend[15];
	wire        dvs_neg = i_word ? i_divisor[15] : i_divisor[7];
	wire [31:0] dvd_sx  = i_word ? i_dividend : {{16{i_dividend[15]}}, i_dividend[15:0]};
	wire [15:0] dvs_sx  = i_word ? i_divisor : {{8{i_divisor[7]}}, i_divisor[7:0]};
	wire [31:0] dvd_mag = dvd_neg ? (32'h0 - dvd_sx) : dvd_sx;
	wire [15:0] dvs_mag = dvs_neg ? (16'h0 - dvs_sx) : dvs_sx;
	wire [16:0] trial   = {rem_ff[15:0], num_ff[31]};
	wire        fits    = trial >= {1'b0, den_ff};
	wire [16:0] nxt_rem = fits ? (trial - {1'b0, den_ff}) : trial;
	wire [15:0] q_mag   = word_ff ? num_ff[15:0] : {8'h0, num_ff[7:0]};
	wire [15:0] r_mag   = rem_ff[15:0];
	wire [15:0] q_sgn   = qneg_ff ? (16'h0 - q_mag) : q_mag;
	wire [15:0] r_sgn   = rneg_ff ? (16'h0 - r_mag) : r_mag;

	// ********************************
	// Iteration
	// ********************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_ff       <= 1'b0;
			cnt_ff        <= 6'h0;
			num_ff        <= 32'h0;
			rem_ff        <= 17'h0;
			den_ff        <= 16'h0;
			qneg_ff       <= 1'b0;
			rneg_ff       <= 1'b0;
			word_ff       <= 1'b0;
			o_done_ff     <= 1'b0;
			o_zero_div_ff <= 1'b0;
			o_quot_ff     <= 16'h0;
			o_rem_ff      <= 16'h0;
		end else begin
			o_done_ff <= 1'b0;
			if (i_start && !busy_ff) begin
				busy_ff       <= 1'b1;
				// Byte division only needs 16 steps, so the dividend is left aligned.
				num_ff        <= i_word ? dvd_mag : {dvd_mag[15:0], 16'h0};
				cnt_ff        <= i_word ? `ALU_DIV_STEPS_WORD : `ALU_DIV_STEPS;
				rem_ff        <= 17'h0;
				den_ff        <= dvs_mag;
				qneg_ff       <= dvd_neg ^ dvs_neg;
				rneg_ff       <= dvd_neg;
				word_ff       <= i_word;
				o_zero_div_ff <= (dvs_sx == 16'h0);
			end else if (busy_ff) begin
				rem_ff <= nxt_rem;
				num_ff <= {num_ff[30:0], fits};
				cnt_ff <= cnt_ff - 6'h1;
				if (cnt_ff == 6'h1) begin
					busy_ff <= 1'b0;
				end
			end
			if (busy_ff && cnt_ff == 6'h0) begin
				busy_ff <= 1'b0;
			end
			if (fin_ff) begin
				o_done_ff <= 1'b1;
				o_quot_ff <= word_ff ? q_sgn : {8'h0, q_sgn[7:0]};
				o_rem_ff  <= word_ff ? r_sgn : {8'h0, r_sgn[7:0]};
			end
		end
	end

	// ********************************
	// Result
	// ********************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fin_ff <= 1'b0;
		end else begin
			fin_ff <= busy_ff && (cnt_ff == 6'h1);
		end
	end

endmodule
`default_nettype wire

// *** alu_core.v ***
// Functional notes
// - Byte divide: 16 by 8, quotient and remainder.
// - Word divide: 32 by 16; byte/word only.
// - Compare subtracts, updates only condition codes.
// - Negate gives zero minus destination.
// - Zero extend low half, upper bits zero.
// - Sign extend low half, replicate its top.
// - AND destination with register or immediate.
// - OR destination with register or immediate.
// - XOR destination with register or immediate.
// - Invert every destination bit at size.
//
// Purpose: Arithmetic and logic datapath slice of the core.
// Assumes: Decoder holds i_start for one cycle and waits for o_done_ff.
// Notes:   Result and flags are registered; division takes extra cycles.
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"

module alu_core (
	input  wire        i_clk,
	input  wire        i_resetn,
	input  wire        i_start,
	input  wire [3:0]  i_op,
	input  wire [1:0]  i_size,
	input  wire        i_use_imm,
	input  wire [31:0] i_dest,
	input  wire [31:0] i_source_register,
	input  wire [31:0] i_immediate_operand,
	output reg         o_done_ff,
	output reg         o_busy_ff,
	output reg  [31:0] o_result_ff,
	output reg         o_write_ff,
	output reg  [3:0]  o_condition_code_register_ff,
	output reg         o_cc_write_ff,
	output reg         o_illegal_ff,
	output reg         o_div_zero_ff
);

	localparam ST_IDLE = 1'b0;
	localparam ST_DIV  = 1'b1;

	reg        state_ff;
	reg [1:0]  div_size_ff;
	reg        div_start_ff;
	wire       div_done;
	wire       div_zero;
	wire [15:0] div_quot;
	wire [15:0] div_rem;

	wire [31:0] opnd = i_use_imm ? i_immediate_operand : i_source_register;

	// ********************************
	// Size helpers
	// ********************************
	function [31:0] fit;
		input [31:0] v;
		input [1:0]  s;
		begin
			case (s)
				`ALU_SZ_BYTE: fit = {24'h0, v[7:0]};
				`ALU_SZ_WORD: fit = {16'h0, v[15:0]};
				default:      fit = v;
			endcase
		end
	endfunction

	function msb;
		input [31:0] v;
		input [1:0]  s;
		begin
			case (s)
				`ALU_SZ_BYTE: msb = v[7];
				`ALU_SZ_WORD: msb = v[15];
				default:      msb = v[31];
			endcase
		end
	endfunction

	function carry;
		input [32:0] v;
		input [1:0]  s;
		begin
			case (s)
				`ALU_SZ_BYTE: carry = v[8];
				`ALU_SZ_WORD: carry = v[16];
				default:      carry = v[32];
			endcase
		end
	endfunction

	// ********************************
	// Combinational datapath
	// ********************************
	reg [31:0] nxt_res;
	reg [3:0]  nxt_cc;
	reg        nxt_wr;
	reg        nxt_ill;
	reg        nxt_div;
	reg [32:0] diff;
	reg [31:0] a;
	reg [31:0] b;
	reg [31:0] r;

	always @* begin
		a       = fit(i_dest, i_size);
		b       = fit(opnd, i_size);
		diff    = {1'b0, a} - {1'b0, b};
		r       = 32'h0;
		nxt_res = i_dest;
		nxt_cc  = o_condition_code_register_ff;
		nxt_wr  = 1'b0;
		nxt_ill = 1'b0;
		nxt_div = 1'b0;
		case (i_op)
			`ALU_OP_SIGNED_DIVIDE: begin
				// Longword is not a divide size; it is refused instead of guessed.
				if (i_size == `ALU_SZ_LONG) begin
					nxt_ill = 1'b1;
				end else begin
					nxt_div = 1'b1;
				end
			end
			`ALU_OP_COMPARE: begin
				r = diff[31:0];
				nxt_cc[`ALU_CC_C] = carry(diff, i_size);
				nxt_cc[`ALU_CC_V] = (msb(a, i_size) ^ msb(b, i_size)) & (msb(a, i_size) ^ msb(r, i_size));
				nxt_cc[`ALU_CC_Z] = (fit(r, i_size) == 32'h0);
				nxt_cc[`ALU_CC_N] = msb(r, i_size);
			end
			`ALU_OP_NEGATE: begin
				diff = {1'b0, 32'h0} - {1'b0, a};
				r    = diff[31:0];
				nxt_wr = 1'b1;
			end
			`ALU_OP_ZERO_EXTEND: begin
				if (i_size == `ALU_SZ_WORD) begin
					r = {16'h0, 8'h0, i_dest[7:0]};
					nxt_wr = 1'b1;
				end else if (i_size == `ALU_SZ_LONG) begin
					r = {16'h0, i_dest[15:0]};
					nxt_wr = 1'b1;
				end else begin
					nxt_ill = 1'b1;
				end
			end
			`ALU_OP_SIGN_EXTEND: begin
				if (i_size == `ALU_SZ_WORD) begin
					r = {16'h0, {8{i_dest[7]}}, i_dest[7:0]};
					nxt_wr = 1'b1;
				end else if (i_size == `ALU_SZ_LONG) begin
					r = {{16{i_dest[15]}}, i_dest[15:0]};
					nxt_wr = 1'b1;
				end else begin
					nxt_ill = 1'b1;
				end
			end
			`ALU_OP_AND: begin
				r = a & b;
				nxt_wr = 1'b1;
			end
			`ALU_OP_OR: begin
				r = a | b;
				nxt_wr = 1'b1;
			end
			`ALU_OP_XOR: begin
				r = a ^ b;
				nxt_wr = 1'b1;
			end
			`ALU_OP_NOT: begin
				r = ~a;
				nxt_wr = 1'b1;
			end
			default: begin
				nxt_ill = 1'b1;
			end
		endcase
		if (nxt_wr) begin
			// Only the selected size is replaced; upper destination bits survive.
			case (i_size)
				`ALU_SZ_BYTE: nxt_res = {i_dest[31:8], r[7:0]};
				`ALU_SZ_WORD: nxt_res = {i_dest[31:16], r[15:0]};
				default:      nxt_res = r;
			endcase
			if (i_op == `ALU_OP_ZERO_EXTEND || i_op == `ALU_OP_SIGN_EXTEND) begin
				nxt_res = (i_size == `ALU_SZ_WORD) ? {i_dest[31:16], r[15:0]} : r;
			end
			nxt_cc[`ALU_CC_N] = msb(r, i_size == `ALU_SZ_BYTE ? `ALU_SZ_BYTE : i_size);
			nxt_cc[`ALU_CC_Z] = (fit(r, i_size) == 32'h0);
			nxt_cc[`ALU_CC_V] = (i_op == `ALU_OP_NEGATE) ? (a != 32'h0 && fit(r, i_size) == a && msb(a, i_size)) : 1'b0;
			if (i_op == `ALU_OP_NEGATE) begin
				nxt_cc[`ALU_CC_C] = (a != 32'h0);
			end
		end
	end

	// ********************************
	// Divider
	// ********************************
	alu_div u_div (
		.i_clk         (i_clk),
		.i_resetn      (i_resetn),
		.i_start       (div_start_ff),
		.i_word        (div_size_ff == `ALU_SZ_WORD),
		.i_dividend    (i_dest),
		.i_divisor     (opnd[15:0]),
		.o_done_ff     (),
		.o_zero_div_ff (div_zero),
		.o_quot_ff     (div_quot),
		.o_rem_ff      (div_rem)
	);

	reg [5:0] div_wait_ff;
	assign div_done = (state_ff == ST_DIV) && (div_wait_ff == 6'h0) && !div_start_ff;

	// ********************************
	// Control and result registers
	// ********************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff                     <= ST_IDLE;
			div_size_ff                  <= `ALU_SZ_BYTE;
			div_start_ff                 <= 1'b0;
			div_wait_ff                  <= 6'h0;
			o_done_ff                    <= 1'b0;
			o_busy_ff                    <= 1'b0;
			o_result_ff                  <= 32'h0;
			o_write_ff                   <= 1'b0;
			o_condition_code_register_ff <= 4'h0;
			o_cc_write_ff                <= 1'b0;
			o_illegal_ff                 <= 1'b0;
			o_div_zero_ff                <= 1'b0;
		end else begin
			o_done_ff     <= 1'b0;
			o_write_ff    <= 1'b0;
			o_cc_write_ff <= 1'b0;
			o_illegal_ff  <= 1'b0;
			div_start_ff  <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (i_start && nxt_div) begin
						state_ff     <= ST_DIV;
						div_size_ff  <= i_size;
						div_start_ff <= 1'b1;
						// Word needs 32 steps, byte 16, plus two for setup and sign fix.
						div_wait_ff  <= (i_size == `ALU_SZ_WORD) ? 6'h22 : 6'h12;
						o_busy_ff    <= 1'b1;
					end else if (i_start) begin
						o_done_ff     <= 1'b1;
						o_illegal_ff  <= nxt_ill;
						o_write_ff    <= nxt_wr;
						o_cc_write_ff <= !nxt_ill;
						o_result_ff   <= nxt_res;
						if (!nxt_ill) begin
							o_condition_code_register_ff <= nxt_cc;
						end
					end
				end
				ST_DIV: begin
					if (div_wait_ff != 6'h0) begin
						div_wait_ff <= div_wait_ff - 6'h1;
					end
					if (div_done) begin
						state_ff      <= ST_IDLE;
						o_busy_ff     <= 1'b0;
						o_done_ff     <= 1'b1;
						o_write_ff    <= 1'b1;
						o_cc_write_ff <= 1'b1;
						o_div_zero_ff <= div_zero;
						// Remainder in the upper half, quotient in the lower half.
						if (div_size_ff == `ALU_SZ_WORD) begin
							o_result_ff <= {div_rem, div_quot};
						end else begin
							o_result_ff <= {i_dest[31:16], div_rem[7:0], div_quot[7:0]};
						end
						o_condition_code_register_ff[`ALU_CC_Z] <= div_zero ? 1'b0 :
							(div_size_ff == `ALU_SZ_WORD ? div_quot == 16'h0 : div_quot[7:0] == 8'h0);
						o_condition_code_register_ff[`ALU_CC_N] <=
							(div_size_ff == `ALU_SZ_WORD) ? div_quot[15] : div_quot[7];
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** alu_core_monitor.sv ***
// Purpose: Port checks for the datapath slice.
// Assumes: Bound into every alu_core instance.
// Notes:   Result checks use longword size, so no upper bits are merged.
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"
module alu_core_monitor (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic        i_start,
	input wire logic [3:0]  i_op,
	input wire logic [1:0]  i_size,
	input wire logic        i_use_imm,
	input wire logic [31:0] i_dest,
	input wire logic [31:0] i_source_register,
	input wire logic [31:0] i_immediate_operand,
	input wire logic        o_done_ff,
	input wire logic        o_busy_ff,
	input wire logic [31:0] o_result_ff,
	input wire logic        o_write_ff,
	input wire logic        o_cc_write_ff
);
	wire        take = i_start && !o_busy_ff;
	wire        tl   = take && i_size == `ALU_SZ_LONG;
	wire [31:0] opnd = i_use_imm ? i_immediate_operand : i_source_register;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property res_p(logic [3:0] code, logic [31:0] v);
		tl && i_op == code |=> o_write_ff && o_result_ff == v;
	endproperty
	and_long_a: assert property (res_p(`ALU_OP_AND, $past(i_dest & opnd)))
		else $error("and result wrong");
	or_long_a: assert property (res_p(`ALU_OP_OR, $past(i_dest | opnd)))
		else $error("or result wrong");
	xor_long_a: assert property (res_p(`ALU_OP_XOR, $past(i_dest ^ opnd)))
		else $error("xor result wrong");
	not_long_a: assert property (res_p(`ALU_OP_NOT, ~$past(i_dest)))
		else $error("not result wrong");
	neg_long_a: assert property (res_p(`ALU_OP_NEGATE, 32'h0 - $past(i_dest)))
		else $error("negate result wrong");
	cmp_no_write_a: assert property (take && i_op == `ALU_OP_COMPARE |=> o_cc_write_ff && !o_write_ff)
		else $error("compare wrote result");
	div_byte_a: assert property (take && i_op == `ALU_OP_SIGNED_DIVIDE && i_size == `ALU_SZ_BYTE |-> ##[2:60] o_done_ff)
		else $error("byte divide hung");
	div_word_a: assert property (take && i_op == `ALU_OP_SIGNED_DIVIDE && i_size == `ALU_SZ_WORD |-> ##[2:60] o_done_ff)
		else $error("word divide hung");
	cover property (take && i_op == `ALU_OP_SIGNED_DIVIDE);
	cover property (o_done_ff && !o_write_ff);
	cover property (i_start && o_busy_ff);
endmodule
bind alu_core alu_core_monitor u_monitor (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(i_start), .i_op(i_op),
	.i_size(i_size), .i_use_imm(i_use_imm), .i_dest(i_dest), .i_source_register(i_source_register),
	.i_immediate_operand(i_immediate_operand), .o_done_ff(o_done_ff), .o_busy_ff(o_busy_ff),
	.o_result_ff(o_result_ff), .o_write_ff(o_write_ff), .o_cc_write_ff(o_cc_write_ff));
`default_nettype wire

// *** alu_core_rf_model.sv ***
// Purpose: Register file model feeding the destination operand.
// Assumes: One destination register suffices for single-issue traffic.
// Notes:   It holds the operand steady until write-back, as a divide needs.
`timescale 1ns/1ps
`default_nettype none
module alu_core_rf_model (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_load,
	input  wire logic [31:0] i_load_val,
	input  wire logic        i_write,
	input  wire logic [31:0] i_result,
	output var  logic [31:0] o_dest_ff
);
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_dest_ff <= 32'h0;
		else if (i_load)
			o_dest_ff <= i_load_val;
		else if (i_write)
			o_dest_ff <= i_result;
	end
endmodule
`default_nettype wire

// *** alu_arith_logic_subset_test.sv ***
// Purpose: Random and corner checks of the datapath slice.
// Assumes: The destination operand comes from the register model.
// Notes:   Divide operands are shaped so the quotient fits; overflow is untested.
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"
module alu_arith_logic_subset_test;
	logic        clk, resetn, start, use_imm, ld, done, busy, wr, ccw, ill, dz;
	logic [3:0]  op, cc;
	logic [1:0]  sz;
	logic [31:0] src, imm, ldv, rd, res, x, y;
	int          bad_count, samples_checked;

	alu_core_rf_model rf (.i_clk(clk), .i_resetn(resetn), .i_load(ld), .i_load_val(ldv), .i_write(wr),
		.i_result(res), .o_dest_ff(rd));
	alu_core dut (.i_clk(clk), .i_resetn(resetn), .i_start(start), .i_op(op), .i_size(sz),
		.i_use_imm(use_imm), .i_dest(rd), .i_source_register(src), .i_immediate_operand(imm),
		.o_done_ff(done), .o_busy_ff(busy), .o_result_ff(res), .o_write_ff(wr),
		.o_condition_code_register_ff(cc), .o_cc_write_ff(ccw), .o_illegal_ff(ill), .o_div_zero_ff(dz));

	always #2.5 clk = ~clk;

	function automatic logic [31:0] expect_of(input logic [3:0] o, input logic [1:0] s, input logic [31:0] d, b);
		logic [31:0]        m, r;
		logic signed [31:0] n, v;
		m = (s == `ALU_SZ_BYTE) ? 32'hff : (s == `ALU_SZ_WORD) ? 32'hffff : 32'hffffffff;
		n = (s == `ALU_SZ_BYTE) ? {{16{d[15]}}, d[15:0]} : d;
		v = (s == `ALU_SZ_BYTE) ? {{24{b[7]}}, b[7:0]} : {{16{b[15]}}, b[15:0]};
		case (o)
			`ALU_OP_SIGNED_DIVIDE: return (s == `ALU_SZ_BYTE) ? {d[31:16], 8'(n % v), 8'(n / v)} : {16'(n % v), 16'(n / v)};
			`ALU_OP_NEGATE: r = 32'h0 - d;
			`ALU_OP_ZERO_EXTEND: r = (s == `ALU_SZ_WORD) ? {24'h0, d[7:0]} : {16'h0, d[15:0]};
			`ALU_OP_SIGN_EXTEND: r = (s == `ALU_SZ_WORD) ? {{24{d[7]}}, d[7:0]} : {{16{d[15]}}, d[15:0]};
			`ALU_OP_AND: r = d & b;
			`ALU_OP_OR: r = d | b;
			`ALU_OP_XOR: r = d ^ b;
			`ALU_OP_NOT: r = ~d;
			default: r = d;
		endcase
		return (r & m) | (d & ~m);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (e !== g) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic run(input logic [3:0] o, input logic [1:0] s, input logic im, input logic [31:0] d, b, input logic poke);
		logic [31:0] e, m;
		logic        got, bad_sz, dv, zero;
		m = (s == `ALU_SZ_BYTE) ? 32'hff : (s == `ALU_SZ_WORD) ? 32'hffff : 32'hffffffff;
		dv = o == `ALU_OP_SIGNED_DIVIDE;
		bad_sz = o > `ALU_OP_NOT || (dv && s == `ALU_SZ_LONG);
		bad_sz = bad_sz || (s == `ALU_SZ_BYTE && (o == `ALU_OP_ZERO_EXTEND || o == `ALU_OP_SIGN_EXTEND));
		zero = dv && !bad_sz && ((s == `ALU_SZ_BYTE) ? b[7:0] == 8'h0 : b[15:0] == 16'h0);
		e = (bad_sz || o == `ALU_OP_COMPARE) ? d : expect_of(o, s, d, b);
		got = 0;
		@(posedge clk);
		ld <= 1;
		ldv <= d;
		@(posedge clk);
		ld <= 0;
		start <= 1;
		op <= o;
		sz <= s;
		use_imm <= im;
		src <= im ? $urandom : b;
		imm <= im ? b : $urandom;
		for (int n = 0; n < 60 && !got; n++) begin
			@(posedge clk);
			start <= poke && n == 4;
			@(negedge clk);
			got = done === 1'b1;
		end
		if (!got) begin
			chk("done", 1, 0);
			report_and_stop();
		end
		chk("illegal", bad_sz, ill);
		if (!zero)
			chk("write", !bad_sz && o != `ALU_OP_COMPARE, wr);
		if (o == `ALU_OP_COMPARE) begin
			chk("flags_write", 1, ccw);
			chk("cmp_zero", (d & m) == (b & m), cc[`ALU_CC_Z]);
			chk("cmp_borrow", (d & m) < (b & m), cc[`ALU_CC_C]);
		end
		if (dv && !bad_sz)
			chk("div_zero", zero, dz);
		if (zero)
			chk("zero_flag", 0, cc[`ALU_CC_Z]);
		else if (!bad_sz && o != `ALU_OP_COMPARE)
			chk("result", e, res);
		@(negedge clk);
		if (!zero)
			chk("register", e, rd);
		if (poke)
			repeat (40) @(negedge clk) chk("ignored_start", 0, done);
	endtask

	initial begin
		{clk, resetn, start, use_imm, ld} = 5'h0;
		{op, sz, src, imm, ldv} = 102'h0;
		bad_count = 0;
		samples_checked = 0;
		x = $urandom(9);
		repeat (3) @(posedge clk);
		resetn <= 1;
		for (int k = 0; k < 216; k++) begin
			x = $urandom;
			y = $urandom;
			if (k / 6 % 9 == 0) begin
				if ((k / 2) % 3 == 1)
					x = {{16{x[15]}}, x[15:0]};
				else
					x[15:8] = {8{x[7]}};
				if (y[15:0] == 16'h0 || y[15:0] == 16'hffff || y[7:0] == 8'h0 || y[7:0] == 8'hff)
					y[7:0] = 8'h05;
			end
			run(4'(k / 6 % 9), 2'((k / 2) % 3), k[0], x, y, 1'b0);
		end
		run(`ALU_OP_SIGNED_DIVIDE, `ALU_SZ_WORD, 1'b0, 32'hffff8001, 32'h2, 1'b1);
		run(`ALU_OP_SIGNED_DIVIDE, `ALU_SZ_BYTE, 1'b1, 32'h1234ff83, 32'h0, 1'b0);
		run(`ALU_OP_NEGATE, `ALU_SZ_BYTE, 1'b0, 32'h12345680, 32'h0, 1'b0);
		run(4'hc, `ALU_SZ_LONG, 1'b0, 32'h5, 32'h3, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
